// [rtl/fep_protect.sv]
// Protection registers, range decode and violation logic for flash and EEPROM.
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
module fep_protect (
   // Clock and reset.
   input  wire logic            clk,
   input  wire logic            rst_n,
   // Mode strap, high in special single-chip mode.
   input  wire logic            specialMode,
   // Configuration load from the reset sequence.
   input  wire logic            cfgLoad,
   input  wire logic [7:0]      cfgFlashByte,
   input  wire logic            cfgFlashDbf,
   input  wire logic [7:0]      cfgEeByte,
   input  wire logic            cfgEeDbf,
   // Command check toward the sequencer.
   input  wire logic            cmdValid,
   input  wire fep_pkg::fep_cmd_s cmd,
   output logic                 cmdGo,
   output logic                 cmdAbort,
   output logic                 violFlag,
   // AXI4-Lite write channels.
   input  wire logic [7:0]      awaddr,
   input  wire logic            awvalid,
   output logic                 awready,
   input  wire logic [31:0]     wdata,
   input  wire logic [3:0]      wstrb,
   input  wire logic            wvalid,
   output logic                 wready,
   output logic [1:0]           bresp,
   output logic                 bvalid,
   input  wire logic            bready,
   // AXI4-Lite read channels.
   input  wire logic [7:0]      araddr,
   input  wire logic            arvalid,
   output logic                 arready,
   output logic [31:0]          rdata,
   output logic [1:0]           rresp,
   output logic                 rvalid,
   input  wire logic            rready
);

   // ==========================================
   // Functions.

   // Size rank of the high range: 0, 1 or 2 for 2, 4, 8 KB.
   function automatic logic [1:0] hiRank(input logic [1:0] sz);
      hiRank = (sz == 2'h0) ? 2'h0 : (sz == 2'h1) ? 2'h1 : 2'h2;
   endfunction

   // True when the address lies in the selected high range.
   function automatic logic inHigh(input logic [23:0] a, input logic [1:0] sz);
      case (hiRank(sz))
         2'h0:    inHigh = (a >= fep_pkg::HI_2K);
         2'h1:    inHigh = (a >= fep_pkg::HI_4K);
         default: inHigh = (a >= fep_pkg::HI_8K);
      endcase
   endfunction

   // True when a flash address is protected under a setting.
   function automatic logic pfHit(input logic [7:0] p, input logic [23:0] a);
      logic hi;
      hi = inHigh(a, p[fep_pkg::POS_HISZ +: 2]);
      case ({p[fep_pkg::POS_OPSEL], p[fep_pkg::POS_HIDIS]})
         2'b11:   pfHit = 1'b0;
         2'b10:   pfHit = hi;
         2'b01:   pfHit = 1'b1;
         default: pfHit = !hi;
      endcase
   endfunction

   // True when the new flash setting protects all that the old one did.
   function automatic logic pfGrows(input logic [7:0] o, input logic [7:0] n);
      logic [1:0] om;
      logic [1:0] nm;
      logic [1:0] orr;
      logic [1:0] nr;
      om  = {o[fep_pkg::POS_OPSEL], o[fep_pkg::POS_HIDIS]};
      nm  = {n[fep_pkg::POS_OPSEL], n[fep_pkg::POS_HIDIS]};
      orr = hiRank(o[fep_pkg::POS_HISZ +: 2]);
      nr  = hiRank(n[fep_pkg::POS_HISZ +: 2]);
      case (om)
         2'b11:   pfGrows = 1'b1;
         2'b10:   pfGrows = (nm == 2'b01) || (nm == 2'b10 && nr >= orr);
         2'b01:   pfGrows = (nm == 2'b01);
         default: pfGrows = (nm == 2'b01) || (nm == 2'b00 && nr <= orr);
      endcase
   endfunction

   // True when an EEPROM address is protected under a setting.
   function automatic logic eeHit(input logic [7:0] e, input logic [23:0] a);
      logic [23:0] lim;
      lim = fep_pkg::EE_BASE + fep_pkg::EE_STEP * {22'h0, e[1:0]};
      eeHit = !e[fep_pkg::POS_EECTL] && (a >= fep_pkg::EE_BASE)
              && (a < lim + fep_pkg::EE_STEP);
   endfunction

   // ==========================================
   // Protection registers.
   logic [7:0] pfProt;  // Program flash protection.
   logic [7:0] eeProt;  // EEPROM protection.

   // Bus write decode.
   logic       wrFire;      // Write taken this edge.
   logic       wrLane;      // Low byte lane enabled.
   logic [7:0] wByte;       // Written byte.
   logic       wrPf;        // Write to flash protection.
   logic       wrEe;        // Write to EEPROM protection.
   logic       wrStat;      // Write to status.
   logic       wrHit;       // Address is mapped.

   assign wrFire = awvalid && wvalid && awready && wready;
   assign wrLane = wstrb[0];
   assign wByte  = wdata[7:0];
   assign wrHit  = (awaddr == fep_pkg::ADDR_PFPROT) ||
                   (awaddr == fep_pkg::ADDR_EEPROT) ||
                   (awaddr == fep_pkg::ADDR_STATUS);
   assign wrPf   = wrFire && wrLane && awaddr == fep_pkg::ADDR_PFPROT;
   assign wrEe   = wrFire && wrLane && awaddr == fep_pkg::ADDR_EEPROT;
   assign wrStat = wrFire && wrLane && awaddr == fep_pkg::ADDR_STATUS;

   // Candidate flash value: the size field follows the old disable bit.
   logic [7:0] next_pfProt;
   always_comb begin
      next_pfProt = wByte;
      if (!pfProt[fep_pkg::POS_HIDIS]) begin
         next_pfProt[fep_pkg::POS_HISZ +: 2] = pfProt[fep_pkg::POS_HISZ +: 2];
      end
   end

   // Flash protection: loaded from the configuration byte, then software.
   // A refused write is dropped whole so a partial shrink cannot slip in.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pfProt <= fep_pkg::PF_FULL;
      end else if (cfgLoad) begin
         if (cfgFlashDbf) begin
            pfProt <= fep_pkg::PF_FULL;
         end else begin
            pfProt <= cfgFlashByte;
         end
      end else if (wrPf) begin
         if (specialMode || pfGrows(pfProt, next_pfProt)) begin
            pfProt <= next_pfProt;
         end
      end
   end

   // EEPROM protection: in normal mode the control bit only falls and
   // the size only rises; each field is judged on its own.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         eeProt <= fep_pkg::EE_FULL;
      end else if (cfgLoad) begin
         if (cfgEeDbf) begin
            eeProt <= fep_pkg::EE_FULL;
         end else begin
            eeProt <= cfgEeByte & fep_pkg::EE_WMASK;
         end
      end else if (wrEe) begin
         if (specialMode) begin
            eeProt <= wByte & fep_pkg::EE_WMASK;
         end else begin
            eeProt[fep_pkg::POS_EECTL] <= eeProt[fep_pkg::POS_EECTL] &
                                          wByte[fep_pkg::POS_EECTL];
            if (wByte[1:0] > eeProt[1:0]) begin
               eeProt[1:0] <= wByte[1:0];
            end
         end
      end
   end

   // ==========================================
   // Command check.
   logic cmdHit;   // Command would alter protected data.

   always_comb begin
      if (cmd.isEe) begin
         case (cmd.op)
            fep_pkg::OP_PROGRAM,
            fep_pkg::OP_SECT_ERASE: cmdHit = eeHit(eeProt, cmd.addr);
            fep_pkg::OP_BLK_ERASE:  cmdHit = !eeProt[fep_pkg::POS_EECTL];
            default:                cmdHit = 1'b0;
         endcase
      end else begin
         case (cmd.op)
            fep_pkg::OP_PROGRAM,
            fep_pkg::OP_SECT_ERASE: cmdHit = pfHit(pfProt, cmd.addr);
            // Every mode but the open one leaves some sector protected.
            fep_pkg::OP_BLK_ERASE:  cmdHit = !(pfProt[fep_pkg::POS_OPSEL] &&
                                               pfProt[fep_pkg::POS_HIDIS]);
            default:                cmdHit = 1'b0;
         endcase
      end
   end

   // Go and abort are one-cycle pulses; a request under a set flag gets
   // neither, so the sequencer sees it refused.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cmdGo    <= 1'b0;
         cmdAbort <= 1'b0;
      end else begin
         cmdGo    <= cmdValid && !violFlag && !cmdHit;
         cmdAbort <= cmdValid && !violFlag && cmdHit;
      end
   end

   // Violation flag: a new violation wins over a clear in the same cycle.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         violFlag <= 1'b0;
      end else if (cmdValid && !violFlag && cmdHit) begin
         violFlag <= 1'b1;
      end else if (wrStat && wByte[fep_pkg::POS_VIOL]) begin
         violFlag <= 1'b0;
      end
   end

   // ==========================================
   // AXI4-Lite write path: address and data are taken together.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         awready <= 1'b0;
         wready  <= 1'b0;
      end else begin
         awready <= awvalid && wvalid && !awready && !bvalid;
         wready  <= awvalid && wvalid && !wready && !bvalid;
      end
   end

   // Write response, held until the master takes it.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         bvalid <= 1'b0;
         bresp  <= fep_pkg::RESP_OKAY;
      end else if (wrFire) begin
         bvalid <= 1'b1;
         bresp  <= wrHit ? fep_pkg::RESP_OKAY : fep_pkg::RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // ==========================================
   // AXI4-Lite read path: one beat, answer held until rready.
   logic [31:0] rdMux;  // Read value for the address.
   logic        rdHit;  // Read address is mapped.

   always_comb begin
      rdMux = 32'h0;
      rdHit = 1'b1;
      case (araddr)
         fep_pkg::ADDR_PFPROT: rdMux = {24'h0, pfProt};
         fep_pkg::ADDR_EEPROT: rdMux = {24'h0, eeProt};
         fep_pkg::ADDR_STATUS: rdMux[fep_pkg::POS_VIOL] = violFlag;
         default:              rdHit = 1'b0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         arready <= 1'b0;
      end else begin
         arready <= arvalid && !arready && !rvalid;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rvalid <= 1'b0;
         rdata  <= 32'h0;
         rresp  <= fep_pkg::RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rdata  <= rdMux;
         rresp  <= rdHit ? fep_pkg::RESP_OKAY : fep_pkg::RESP_SLVERR;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end

   // ==========================================
   // Assertions.
   property p_load_pf;
      @(posedge clk) disable iff (!rst_n)
      cfgLoad && !cfgFlashDbf |=> pfProt == $past(cfgFlashByte);
   endproperty
   a_load_pf: assert property (p_load_pf) else $error("flash load wrong");

   property p_dbf_pf;
      @(posedge clk) disable iff (!rst_n)
      cfgLoad && cfgFlashDbf |=> pfProt == fep_pkg::PF_FULL;
   endproperty
   a_dbf_pf: assert property (p_dbf_pf) else $error("flash fault load wrong");

   property p_load_ee;
      @(posedge clk) disable iff (!rst_n)
      cfgLoad && !cfgEeDbf |=> eeProt == ($past(cfgEeByte) & fep_pkg::EE_WMASK);
   endproperty
   a_load_ee: assert property (p_load_ee) else $error("eeprom load wrong");

   property p_dbf_ee;
      @(posedge clk) disable iff (!rst_n)
      cfgLoad && cfgEeDbf |=> eeProt == fep_pkg::EE_FULL;
   endproperty
   a_dbf_ee: assert property (p_dbf_ee) else $error("eeprom fault load wrong");

   property p_pf_grow;
      @(posedge clk) disable iff (!rst_n)
      !specialMode && !cfgLoad |=> pfGrows($past(pfProt), pfProt);
   endproperty
   a_pf_grow: assert property (p_pf_grow) else $error("flash protection shrank");

   property p_hisz_lock;
      @(posedge clk) disable iff (!rst_n)
      !cfgLoad && !pfProt[fep_pkg::POS_HIDIS] |=> $stable(pfProt[fep_pkg::POS_HISZ +: 2]);
   endproperty
   a_hisz_lock: assert property (p_hisz_lock) else $error("size field changed");

   property p_ee_ctl;
      @(posedge clk) disable iff (!rst_n)
      !specialMode && !cfgLoad && !eeProt[fep_pkg::POS_EECTL] |=> !eeProt[fep_pkg::POS_EECTL];
   endproperty
   a_ee_ctl: assert property (p_ee_ctl) else $error("eeprom control reopened");

   property p_ee_size;
      @(posedge clk) disable iff (!rst_n)
      !specialMode && !cfgLoad |=> eeProt[1:0] >= $past(eeProt[1:0]);
   endproperty
   a_ee_size: assert property (p_ee_size) else $error("eeprom size shrank");

   property p_viol_block;
      @(posedge clk) disable iff (!rst_n)
      violFlag && cmdValid |=> !cmdGo && !cmdAbort;
   endproperty
   a_viol_block: assert property (p_viol_block) else $error("launch under flag");

   property p_abort_flag;
      @(posedge clk) disable iff (!rst_n)
      cmdAbort |-> violFlag && !cmdGo;
   endproperty
   a_abort_flag: assert property (p_abort_flag) else $error("abort without flag");

   // Under full flash protection every program request made with the flag clear must be aborted.
   property p_full_pf;
      @(posedge clk) disable iff (!rst_n)
      cmdValid && !violFlag && !cmd.isEe && cmd.op == fep_pkg::OP_PROGRAM &&
      !pfProt[fep_pkg::POS_OPSEL] && pfProt[fep_pkg::POS_HIDIS] |=> cmdAbort && violFlag;
   endproperty
   a_full_pf: assert property (p_full_pf) else $error("program under full protection");

   // Flash block erase only goes ahead with protection fully open.
   property p_blk_pf;
      @(posedge clk) disable iff (!rst_n)
      cmdValid && !violFlag && !cmd.isEe && cmd.op == fep_pkg::OP_BLK_ERASE &&
      !(pfProt[fep_pkg::POS_OPSEL] && pfProt[fep_pkg::POS_HIDIS]) |=> cmdAbort && !cmdGo;
   endproperty
   a_blk_pf: assert property (p_blk_pf) else $error("flash block erase let through");

   // EEPROM block erase is refused while any EEPROM sector is protected.
   property p_blk_ee;
      @(posedge clk) disable iff (!rst_n)
      cmdValid && !violFlag && cmd.isEe && cmd.op == fep_pkg::OP_BLK_ERASE &&
      !eeProt[fep_pkg::POS_EECTL] |=> cmdAbort && !cmdGo;
   endproperty
   a_blk_ee: assert property (p_blk_ee) else $error("eeprom block erase let through");

   // With the control bit set the size field must not block anything.
   property p_ee_open;
      @(posedge clk) disable iff (!rst_n)
      cmdValid && !violFlag && cmd.isEe && eeProt[fep_pkg::POS_EECTL] |=> cmdGo;
   endproperty
   a_ee_open: assert property (p_ee_open) else $error("open eeprom refused");

   // The flag only drops on a one written to its status bit.
   property p_viol_hold;
      @(posedge clk) disable iff (!rst_n)
      violFlag && !(wrStat && wByte[fep_pkg::POS_VIOL]) |=> violFlag;
   endproperty
   a_viol_hold: assert property (p_viol_hold) else $error("flag dropped without clear");

   c_abort: cover property (@(posedge clk) disable iff (!rst_n) cmdAbort);
   c_go:    cover property (@(posedge clk) disable iff (!rst_n) cmdGo);
   c_clear: cover property (@(posedge clk) disable iff (!rst_n) violFlag ##1 !violFlag);
   c_reload: cover property (@(posedge clk) disable iff (!rst_n) cfgLoad);
   c_refuse: cover property (@(posedge clk) disable iff (!rst_n) violFlag && cmdValid);

endmodule

// [rtl/fep_pkg.sv]
// Package of constants and types for the flash and EEPROM protection block.
// Contract
// - Normal mode: flash protection writes never shrink.
// - Special mode: protection bits freely writable; the flash size field still takes a write only while the old disable bit is set.
// - Reset load flash protection from config byte.
// - Load double fault: flash fully protected.
// - Flash protected target sets violation flag.
// - Flash block erase refused if protected.
// - Mode decoded from operation and disable bits.
// - High size code selects 2/4/8 KB.
// - High size writable only while disable set.
// - Normal mode: EEPROM size may only grow.
// - Normal mode: EEPROM control only one-to-zero.
// - EEPROM control set disables EEPROM protection.
// - Reset load EEPROM protection from config.
// - Load double fault: EEPROM fully protected.
// - EEPROM protected target sets violation flag.
// - EEPROM block erase refused if protected.
// - EEPROM region from base, 32-128 bytes.
// - Flag blocks launches; cleared by writing one.
package fep_pkg;

   // ==========================================
   // Register map, byte addresses.
   localparam logic [7:0] ADDR_STATUS = 8'h00; // Status, flag is write-one-to-clear.
   localparam logic [7:0] ADDR_PFPROT = 8'h08; // Program flash protection.
   localparam logic [7:0] ADDR_EEPROT = 8'h0c; // EEPROM protection.

   // ==========================================
   // Field positions.
   localparam int POS_OPSEL   = 7; // Protection operation select.
   localparam int POS_HIDIS   = 5; // High range disable.
   localparam int POS_HISZ    = 3; // Low bit of high range size.
   localparam int POS_EECTL   = 7; // EEPROM protection control.
   localparam int POS_VIOL    = 4; // Violation flag in status.
   localparam logic [7:0] EE_WMASK = 8'h83; // Implemented EEPROM bits.

   // ==========================================
   // Reset and fault values: everything protected.
   localparam logic [7:0] PF_FULL = 8'h7f;
   localparam logic [7:0] EE_FULL = 8'h03;

   // ==========================================
   // Address space.
   localparam logic [23:0] CFG_PF_BYTE = 24'hff_fe0c; // Source of flash byte.
   localparam logic [23:0] CFG_EE_BYTE = 24'hff_fe0d; // Source of EEPROM byte.
   localparam logic [23:0] HI_2K  = 24'hff_f800;
   localparam logic [23:0] HI_4K  = 24'hff_f000;
   localparam logic [23:0] HI_8K  = 24'hff_e000;
   localparam logic [23:0] EE_BASE = 24'h10_0000;
   localparam logic [23:0] EE_STEP = 24'h00_0020; // 32 bytes per size step.

   // ==========================================
   // Bus answers.
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Command operations seen from the sequencer.
   typedef enum logic [1:0] {
      OP_PROGRAM,
      OP_SECT_ERASE,
      OP_BLK_ERASE,
      OP_OTHER
   } fep_op_e;

   // One command request.
   typedef struct packed {
      logic        isEe;  // Target is the EEPROM array.
      fep_op_e     op;    // Operation kind.
      logic [23:0] addr;  // Global target address.
   } fep_cmd_s;

endpackage

// [verification/fep_seq_model.sv]
// Behavioural command sequencer that asks the protection block for permission.
`timescale 1ns/1ps
module fep_seq_model (
   // Clock.
   input  wire logic         clk,
   // Answers from the protection block.
   input  wire logic         cmdGo,
   input  wire logic         cmdAbort,
   // Command request toward the protection block.
   output logic              cmdValid,
   output fep_pkg::fep_cmd_s cmd
);
   // ==========================================
   // Request driver.
   // Idle values at time zero, so the block never sees an unknown request.
   initial begin
      cmdValid = 1'b0;
      cmd      = '0;
   end

   // Offers one request for a single edge, then samples the answer one cycle later.
   task automatic issue(input fep_pkg::fep_cmd_s c, output logic go, output logic abort);
      cmdValid <= 1'b1;
      cmd      <= c;
      @(posedge clk);
      cmdValid <= 1'b0;
      // The released payload is inverted so nothing can lean on a stale address.
      cmd      <= fep_pkg::fep_cmd_s'(~c);
      @(posedge clk);
      go    = cmdGo;
      abort = cmdAbort;
   endtask
endmodule

// [verification/tb.sv]
// Self-checking testbench for the flash and EEPROM protection block.
`timescale 1ns/1ps
module tb;
   // ==========================================
   // Signals.
   logic              clk, rst_n, specialMode, cfgLoad, cfgFlashDbf, cfgEeDbf;
   logic [7:0]        cfgFlashByte, cfgEeByte, awaddr, araddr;
   logic              cmdValid, cmdGo, cmdAbort, violFlag;
   fep_pkg::fep_cmd_s cmd;
   logic              awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [31:0]       wdata, rdata;
   logic [3:0]        wstrb;
   logic [1:0]        bresp, rresp;
   int                errorCnt, nChecks;

   fep_protect fep_protect_i (.clk(clk), .rst_n(rst_n), .specialMode(specialMode), .cfgLoad(cfgLoad),
      .cfgFlashByte(cfgFlashByte), .cfgFlashDbf(cfgFlashDbf), .cfgEeByte(cfgEeByte), .cfgEeDbf(cfgEeDbf),
      .cmdValid(cmdValid), .cmd(cmd), .cmdGo(cmdGo), .cmdAbort(cmdAbort), .violFlag(violFlag),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
   fep_seq_model fep_seq_model_i (.clk(clk), .cmdGo(cmdGo), .cmdAbort(cmdAbort), .cmdValid(cmdValid), .cmd(cmd));

   // 25 MHz clock.
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // ==========================================
   // Shared tasks.
   task automatic endOfTest();
      if (errorCnt == 0 && nChecks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      nChecks++;
      if (got !== exp) begin
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
         errorCnt++;
      end
   endtask

   // A stuck handshake counts as a mismatch and ends the run.
   task automatic timeoutCheck(input int n);
      if (n >= 50) begin
         $display("unexpected bus handshake: expected answer, seen none");
         errorCnt++;
         endOfTest();
      end
   endtask

   // One write; address and data are offered together, each released when taken.
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = fep_pkg::RESP_OKAY);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (!(awready === 1'b1 && wready === 1'b1) && n < 50);
      while (bvalid !== 1'b1 && n < 50) begin
         @(posedge clk);
         n++;
      end
      timeoutCheck(n);
      check("bresp", {30'h0, er}, {30'h0, bresp});
   endtask

   // One read, judged against an expected byte and response.
   task automatic rdChk(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er = fep_pkg::RESP_OKAY);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (arready !== 1'b1 && n < 50);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1 && n < 50) begin
         @(posedge clk);
         n++;
      end
      timeoutCheck(n);
      check("rdata", {24'h0, e}, rdata);
      check("rresp", {30'h0, er}, {30'h0, rresp});
   endtask

   // Asks for one command; a refused one must raise the flag, which is then cleared.
   task automatic cmdChk(input logic ee, input fep_pkg::fep_op_e op, input logic [23:0] a, input logic ab);
      fep_pkg::fep_cmd_s c;
      logic              go, abt;
      c.isEe = ee;
      c.op   = op;
      c.addr = a;
      fep_seq_model_i.issue(c, go, abt);
      check("cmdGo", {31'h0, ~ab}, {31'h0, go});
      check("cmdAbort", {31'h0, ab}, {31'h0, abt});
      check("violFlag", {31'h0, ab}, {31'h0, violFlag});
      if (ab) begin
         wr(fep_pkg::ADDR_STATUS, 8'h10);
         check("violFlag cleared", 32'h0, {31'h0, violFlag});
      end
   endtask

   // Reserved bits stay erased; passing through an open high range lets the size field take.
   task automatic setPf(input logic [7:0] v);
      wr(fep_pkg::ADDR_PFPROT, 8'hff);
      wr(fep_pkg::ADDR_PFPROT, v);
   endtask

   task automatic pulseCfg(input logic [7:0] fb, input logic fd, input logic [7:0] eb, input logic ed);
      cfgLoad <= 1'b1;
      cfgFlashByte <= fb;
      cfgFlashDbf <= fd;
      cfgEeByte <= eb;
      cfgEeDbf <= ed;
      @(posedge clk);
      cfgLoad <= 1'b0;
      @(posedge clk);
   endtask

   // ==========================================
   // Scenarios.
   task automatic tResetLoad();
      rdChk(fep_pkg::ADDR_PFPROT, 8'h7f);
      rdChk(fep_pkg::ADDR_EEPROT, 8'h03);
      rdChk(8'h04, 8'h00, fep_pkg::RESP_SLVERR);
      wr(8'h04, 8'h00, fep_pkg::RESP_SLVERR);
      cmdChk(1'b0, fep_pkg::OP_PROGRAM, fep_pkg::CFG_PF_BYTE, 1'b1);
      pulseCfg(8'hff, 1'b0, 8'h80, 1'b0);
      rdChk(fep_pkg::ADDR_PFPROT, 8'hff);
      rdChk(fep_pkg::ADDR_EEPROT, 8'h80);
      cmdChk(1'b0, fep_pkg::OP_PROGRAM, fep_pkg::CFG_EE_BYTE, 1'b0);
      pulseCfg(8'hff, 1'b1, 8'h80, 1'b1);
      rdChk(fep_pkg::ADDR_PFPROT, 8'h7f);
      rdChk(fep_pkg::ADDR_EEPROT, 8'h03);
   endtask

   // Every protection mode and size code; the 2, 4 and 8 KB boundaries are each tried from both sides, the 8 KB one across two codes.
   task automatic tFlashModes();
      logic [7:0]  v[10] = '{8'hff, 8'hc7, 8'hc7, 8'hcf, 8'hcf, 8'hd7, 8'hdf, 8'h7f, 8'h47, 8'h47};
      logic [23:0] a[10] = '{24'hffffff, 24'hfff800, 24'hfff7ff, 24'hfff000, 24'hffefff,
                             24'hffe000, 24'hffdfff, 24'hfe0000, 24'hfff800, 24'hfff7ff};
      logic        e[10] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
      specialMode <= 1'b1;
      for (int i = 0; i < 10; i++) begin
         setPf(v[i]);
         cmdChk(1'b0, (i % 2) ? fep_pkg::OP_SECT_ERASE : fep_pkg::OP_PROGRAM, a[i], e[i]);
      end
      cmdChk(1'b0, fep_pkg::OP_OTHER, 24'hfe0000, 1'b0);
      setPf(8'hff);
      cmdChk(1'b0, fep_pkg::OP_BLK_ERASE, 24'hfe0000, 1'b0);
      setPf(8'hc7);
      cmdChk(1'b0, fep_pkg::OP_BLK_ERASE, 24'hfe0000, 1'b1);
   endtask

   // A raised flag refuses commands and ignores a zero write.
   task automatic tViolHold();
      logic go, abt;
      setPf(8'h7f);
      cmdChk(1'b0, fep_pkg::OP_PROGRAM, 24'hfe0000, 1'b1);
      fep_seq_model_i.issue('{isEe: 1'b0, op: fep_pkg::OP_PROGRAM, addr: 24'hfe0000}, go, abt);
      check("setting cmdAbort", 32'h1, {31'h0, abt});
      fep_seq_model_i.issue('{isEe: 1'b0, op: fep_pkg::OP_OTHER, addr: 24'h000000}, go, abt);
      check("refused cmdGo", 32'h0, {31'h0, go});
      check("refused cmdAbort", 32'h0, {31'h0, abt});
      wr(fep_pkg::ADDR_STATUS, 8'h00);
      rdChk(fep_pkg::ADDR_STATUS, 8'h10);
      wr(fep_pkg::ADDR_STATUS, 8'h10);
      rdChk(fep_pkg::ADDR_STATUS, 8'h00);
   endtask

   task automatic tFlashNormal();
      setPf(8'hc7);
      wr(fep_pkg::ADDR_PFPROT, 8'hcf);
      rdChk(fep_pkg::ADDR_PFPROT, 8'hc7);
      setPf(8'hff);
      specialMode <= 1'b0;
      wr(fep_pkg::ADDR_PFPROT, 8'hc7);
      rdChk(fep_pkg::ADDR_PFPROT, 8'hc7);
      wr(fep_pkg::ADDR_PFPROT, 8'hff);
      rdChk(fep_pkg::ADDR_PFPROT, 8'hc7);
      specialMode <= 1'b1;
   endtask

   task automatic tEeprom();
      logic [23:0] top;
      wr(fep_pkg::ADDR_EEPROT, 8'h80);
      cmdChk(1'b1, fep_pkg::OP_PROGRAM, fep_pkg::EE_BASE, 1'b0);
      cmdChk(1'b1, fep_pkg::OP_BLK_ERASE, fep_pkg::EE_BASE, 1'b0);
      for (int s = 0; s < 4; s++) begin
         top = fep_pkg::EE_BASE + fep_pkg::EE_STEP * 24'(s + 1);
         wr(fep_pkg::ADDR_EEPROT, 8'(s));
         cmdChk(1'b1, fep_pkg::OP_PROGRAM, top - 24'h1, 1'b1);
         cmdChk(1'b1, fep_pkg::OP_SECT_ERASE, top, 1'b0);
         cmdChk(1'b1, fep_pkg::OP_BLK_ERASE, top, 1'b1);
      end
      wr(fep_pkg::ADDR_EEPROT, 8'h81);
      specialMode <= 1'b0;
      wr(fep_pkg::ADDR_EEPROT, 8'h00);
      rdChk(fep_pkg::ADDR_EEPROT, 8'h01);
      wr(fep_pkg::ADDR_EEPROT, 8'h82);
      rdChk(fep_pkg::ADDR_EEPROT, 8'h02);
      wr(fep_pkg::ADDR_EEPROT, 8'h81);
      rdChk(fep_pkg::ADDR_EEPROT, 8'h02);
      specialMode <= 1'b1;
      wr(fep_pkg::ADDR_EEPROT, 8'h80);
      rdChk(fep_pkg::ADDR_EEPROT, 8'h80);
      // A write without the low byte lane is answered but leaves the register alone.
      wstrb <= 4'he;
      wr(fep_pkg::ADDR_EEPROT, 8'h00);
      wstrb <= 4'hf;
      rdChk(fep_pkg::ADDR_EEPROT, 8'h80);
   endtask

   // ==========================================
   // Main sequence.
   initial begin
      {rst_n, specialMode, cfgLoad, cfgFlashDbf, cfgEeDbf, awvalid, wvalid, arvalid} = '0;
      {cfgFlashByte, cfgEeByte, awaddr, araddr, wdata} = '0;
      wstrb = 4'hf;
      // Responses are always accepted at once, so no answer is ever held off.
      bready = 1'b1;
      rready = 1'b1;
      errorCnt = 0;
      nChecks = 0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      tResetLoad();
      tFlashModes();
      tViolHold();
      tFlashNormal();
      tEeprom();
      endOfTest();
   end
endmodule
